// [hdl/ekw_pkg.sv]
// Constants and shared types for the edge kicked watchdog
package ekw_pkg;

  // System clock rate
  localparam int unsigned CLK_HZ         = 25_000_000;
  localparam int unsigned CLK_PER_US     = CLK_HZ / 1_000_000;

  // Nominal watchdog timeout, in microseconds
  localparam int unsigned TIMEOUT_US     = 1_600_000;
  // Nominal timeout in clock cycles
  localparam int unsigned TIMEOUT_CYC    = TIMEOUT_US * CLK_PER_US;

  // Least fault pulse period, in microseconds
  localparam int unsigned PULSE_US       = 140_000;
  // In cycles; microsecond scaling keeps the product inside 32 bits
  localparam int unsigned PULSE_CYC      = PULSE_US * CLK_PER_US;

  // Self-service driver goes high for the last eighth of the timeout
  localparam int unsigned SELF_NUM       = 7;
  localparam int unsigned SELF_DEN       = 8;

  // Counter widths, wide enough for the default counts
  localparam int unsigned TIMER_W        = 26;
  localparam int unsigned PULSE_W        = 22;

  // Reset values
  localparam logic        FAULT_N_RST    = 1'b0;
  localparam logic        KICK_DRV_RST   = 1'b0;
  localparam logic        SYNC_RST       = 1'b0;

  // Gray coded states: lockout -> pulse -> count -> pulse ...
  typedef enum logic [1:0] {
    EKW_ST_LOCKOUT = 2'h0,
    EKW_ST_PULSE   = 2'h1,
    EKW_ST_COUNT   = 2'h3
  } ekw_state_type;

  // Why the fault output is low
  typedef enum logic [1:0] {
    EKW_CAUSE_NONE    = 2'h0,
    EKW_CAUSE_LOCKOUT = 2'h1,
    EKW_CAUSE_TIMEOUT = 2'h2
  } ekw_cause_type;

endpackage

// [hdl/ekw_sync.sv]
// Two-flop synchroniser with level and edge detection
`timescale 1ns/1ns

module ekw_sync (
  input  wire logic clk_sys,
  input  wire logic arst_n,
  input  wire logic async_in,
  output logic      level,
  output logic      any_edge,
  output logic      rise,
  output logic      fall
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } ekw_sync_regs_type;

  localparam ekw_sync_regs_type SYNC_RESET = '{
    meta: ekw_pkg::SYNC_RST,
    sync: ekw_pkg::SYNC_RST,
    prev: ekw_pkg::SYNC_RST
  };

  ekw_sync_regs_type r_q;
  ekw_sync_regs_type r_d;

  always_comb begin
    r_d      = r_q;
    r_d.meta = async_in;
    // Only the second flop reads the first one
    r_d.sync = r_q.meta;
    r_d.prev = r_q.sync;
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      r_q <= SYNC_RESET;
    end else begin
      r_q <= r_d;
    end
  end

  assign level    = r_q.sync;
  assign any_edge = r_q.sync ^ r_q.prev;
  assign rise     = r_q.sync & ~r_q.prev;
  assign fall     = ~r_q.sync & r_q.prev;

endmodule

// [hdl/ekw_watchdog.sv]
// Edge kicked watchdog with self-servicing kick driver
`timescale 1ns/1ns

// What this block does
// [RQ1] On timer expiry the fault output goes low for at least the pulse period.
// [RQ2] Fault stays low during supply-low lockout and one pulse period after.
// [RQ3] A kick input held at one level past the timeout lets the timer expire.
// [RQ4] Every kick edge, and every fault pulse, clears the watchdog timer.
// [RQ5] The nominal timeout is 1.6 s without a kick edge.
// [RQ6] Kick pulses of 50 ns or wider count as valid service events.
// [RQ7] While the fault output is low the timer is held at zero.
// [RQ8] The timer restarts from zero the moment the fault output is released.
// [RQ9] The kick pin is weakly driven low for 7/8 of the timeout, high after.
// [RQ10] With the pin open the self-service clears the timer about every 1.4 s.
// [RQ11] Leaving the kick pin floating in effect disables the watchdog.
// [RQ12] The processor should keep the pin low and pulse it once per 7/8 period.
// [RQ13] The processor should set and clear the pin at separate program points.
// [RQ14] Times are cycle counts; the kick pin is synchronised and edge detected.
module ekw_watchdog #(
  parameter int unsigned TIMEOUT_CYC = ekw_pkg::TIMEOUT_CYC,
  parameter int unsigned PULSE_CYC   = ekw_pkg::PULSE_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  input  wire logic        kick_input_in,
  output logic             kick_input_out,
  output logic             kick_input_oe,
  input  wire logic        supply_low_lockout,
  output logic             fault_pulse_n,
  output logic [1:0]       fault_cause,
  output logic             timeout_event,
  output logic             kick_event
);

  // Threshold at which the self-service driver turns high
  localparam int unsigned SELF_CYC =
    (TIMEOUT_CYC / ekw_pkg::SELF_DEN) * ekw_pkg::SELF_NUM;

  // Counter end points, cut to the counter widths
  localparam logic [ekw_pkg::TIMER_W-1:0] TIMER_LAST =
    ekw_pkg::TIMER_W'(TIMEOUT_CYC - 1);
  localparam logic [ekw_pkg::TIMER_W-1:0] TIMER_SELF =
    ekw_pkg::TIMER_W'(SELF_CYC);
  localparam logic [ekw_pkg::PULSE_W-1:0] PULSE_LAST =
    ekw_pkg::PULSE_W'(PULSE_CYC - 1);
  localparam logic [ekw_pkg::TIMER_W-1:0] TIMER_ONE  =
    ekw_pkg::TIMER_W'(1);
  localparam logic [ekw_pkg::PULSE_W-1:0] PULSE_ONE  =
    ekw_pkg::PULSE_W'(1);

  // Whole state of the block but the synchroniser flops, registered in one place
  typedef struct packed {
    ekw_pkg::ekw_state_type       state;
    logic [ekw_pkg::TIMER_W-1:0]  timer;
    logic [ekw_pkg::PULSE_W-1:0]  pulse;
    logic                         fault_n;
    logic                         kick_drv;
    ekw_pkg::ekw_cause_type       cause;
    logic                         timeout_ev;
    logic                         kick_ev;
  } ekw_regs_type;

  // Reset behaves as a power-up: a full pulse period before release
  localparam ekw_regs_type REGS_RESET = '{
    state:      ekw_pkg::EKW_ST_PULSE,
    timer:      '0,
    pulse:      '0,
    fault_n:    ekw_pkg::FAULT_N_RST,
    kick_drv:   ekw_pkg::KICK_DRV_RST,
    cause:      ekw_pkg::EKW_CAUSE_LOCKOUT,
    timeout_ev: 1'b0,
    kick_ev:    1'b0
  };

  ekw_regs_type r_q;
  ekw_regs_type r_d;

  logic                        kick_edge;
  logic                        lockout_sync;
  logic                        counting;
  logic                        kick_seen;
  logic                        timer_last;
  logic                        pulse_last;
  logic [ekw_pkg::TIMER_W-1:0] timer_next;
  logic [ekw_pkg::PULSE_W-1:0] pulse_next;

  // [RQ14] Kick pin synchroniser
  // [RQ6] Any pulse wider than one clock period is sampled at least once
  // Two flops cost two cycles of kick latency, far inside the timeout
  ekw_sync u_kick_sync (
    .clk_sys  (clk_sys),
    .arst_n   (arst_n),
    .async_in (kick_input_in),
    .level    (),
    .any_edge (kick_edge),
    .rise     (),
    .fall     ()
  );

  // Lockout comes from an analog detector, so it is synchronised too
  ekw_sync u_lockout_sync (
    .clk_sys  (clk_sys),
    .arst_n   (arst_n),
    .async_in (supply_low_lockout),
    .level    (lockout_sync),
    .any_edge (),
    .rise     (),
    .fall     ()
  );

  // Only the counting state has the fault output released
  assign counting   = (r_q.state == ekw_pkg::EKW_ST_COUNT);
  // [RQ7] Edges during a fault pulse or lockout are not service events
  assign kick_seen  = kick_edge & counting;
  // [RQ5] Last count of the timeout period
  assign timer_last = (r_q.timer == TIMER_LAST);
  // [RQ1] Last cycle of the fault pulse
  assign pulse_last = (r_q.pulse == PULSE_LAST);
  // Neither counter wraps: each is cleared before its increment overflows
  assign timer_next = r_q.timer + TIMER_ONE;
  assign pulse_next = r_q.pulse + PULSE_ONE;

  always_comb begin
    r_d            = r_q;
    r_d.timeout_ev = 1'b0;
    r_d.kick_ev    = 1'b0;

    // One case over the state; the self-service level follows it
    case (r_q.state)
      ekw_pkg::EKW_ST_LOCKOUT: begin
        // [RQ2] Held low for the whole lockout
        // Kick edges are dropped; the timer restarts only after the pulse
        r_d.fault_n = 1'b0;
        r_d.cause   = ekw_pkg::EKW_CAUSE_LOCKOUT;
        r_d.timer   = '0;
        r_d.pulse   = '0;
        if (!lockout_sync) begin
          r_d.state = ekw_pkg::EKW_ST_PULSE;
        end
      end

      ekw_pkg::EKW_ST_PULSE: begin
        // [RQ7] Timer held at zero while the fault is asserted
        r_d.timer   = '0;
        r_d.fault_n = 1'b0;
        if (lockout_sync) begin
          // [RQ2] Lockout restarts the whole pulse after it ends
          r_d.state = ekw_pkg::EKW_ST_LOCKOUT;
          r_d.cause = ekw_pkg::EKW_CAUSE_LOCKOUT;
          r_d.pulse = '0;
        end else if (pulse_last) begin
          // [RQ8] Release and count from zero at once
          r_d.state   = ekw_pkg::EKW_ST_COUNT;
          r_d.fault_n = 1'b1;
          r_d.cause   = ekw_pkg::EKW_CAUSE_NONE;
          r_d.pulse   = '0;
        end else begin
          // [RQ1] Fault pulse lasts the pulse period
          r_d.pulse = pulse_next;
        end
      end

      ekw_pkg::EKW_ST_COUNT: begin
        r_d.fault_n = 1'b1;
        r_d.pulse   = '0;
        // [RQ2] Lockout wins over a kick in the same cycle
        if (lockout_sync) begin
          r_d.state   = ekw_pkg::EKW_ST_LOCKOUT;
          r_d.fault_n = 1'b0;
          r_d.cause   = ekw_pkg::EKW_CAUSE_LOCKOUT;
          r_d.timer   = '0;
        end else if (kick_seen) begin
          // [RQ4] Either edge clears the timer, even at the last count
          r_d.timer   = '0;
          r_d.kick_ev = 1'b1;
        end else if (timer_last) begin
          // [RQ3] [RQ5] No edge within the timeout: start a fault pulse
          // [RQ4] Pulse entry clears the timer
          r_d.state      = ekw_pkg::EKW_ST_PULSE;
          r_d.fault_n    = 1'b0;
          r_d.cause      = ekw_pkg::EKW_CAUSE_TIMEOUT;
          r_d.timer      = '0;
          r_d.timeout_ev = 1'b1;
        end else begin
          r_d.timer = timer_next;
        end
      end

      default: begin
        r_d = REGS_RESET;
      end
    endcase

    // [RQ9] Self-service level follows the counter chain
    // [RQ10] [RQ11] An open pin sees its own edge at 7/8 and is cleared
    // Taken from the next timer so pin and count change on the same edge
    if (r_d.state == ekw_pkg::EKW_ST_COUNT && r_d.timer >= TIMER_SELF) begin
      r_d.kick_drv = 1'b1;
    end else begin
      r_d.kick_drv = 1'b0;
    end
  end

  // Asynchronous reset puts the block into its power-up pulse
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      r_q <= REGS_RESET;
    end else begin
      r_q <= r_d;
    end
  end

  // All outputs but the enable come straight from the state flops
  // Weak driver is always on; a real external driver overrides it
  assign kick_input_oe  = 1'b1;
  assign kick_input_out = r_q.kick_drv;
  assign fault_pulse_n  = r_q.fault_n;
  assign fault_cause    = r_q.cause;
  assign timeout_event  = r_q.timeout_ev;
  assign kick_event     = r_q.kick_ev;

endmodule

// [testbench/ekw_cpu_model.sv]
// Processor output pin that services the kick input
`timescale 1ns/1ns
module ekw_cpu_model (
  input  wire logic drive_en,
  input  wire logic drive_lvl,
  input  wire logic kick_input_out,
  input  wire logic kick_input_oe,
  output logic      kick_pin
);
  assign kick_pin = drive_en ? drive_lvl : kick_input_oe & kick_input_out;
endmodule

// [testbench/ekw_watchdog_monitor.sv]
// Port assertions for the edge kicked watchdog
`timescale 1ns/1ns
module ekw_watchdog_monitor #(
  parameter int unsigned TIMEOUT_CYC = 64,
  parameter int unsigned PULSE_CYC   = 10
) (
  input wire logic       clk_sys,
  input wire logic       arst_n,
  input wire logic       kick_input_out,
  input wire logic       kick_input_oe,
  input wire logic       supply_low_lockout,
  input wire logic       fault_pulse_n,
  input wire logic [1:0] fault_cause,
  input wire logic       timeout_event,
  input wire logic       kick_event
);
  localparam int unsigned SELF = (TIMEOUT_CYC / 8) * 7;
  // High cycles since the last kick, and low cycles of the fault
  logic [7:0] hi_q;
  logic [7:0] lo_q;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      hi_q <= 8'h00;
      lo_q <= 8'h00;
    end else begin
      hi_q <= !fault_pulse_n ? 8'h00 : kick_event ? 8'h01 : hi_q + 8'h01;
      lo_q <= fault_pulse_n ? 8'h00 : lo_q + {7'h00, lo_q != 8'hff};
    end
  end
  sequence held_s; !fault_pulse_n && fault_cause == 2'h1; endsequence
  sequence rel_s; $rose(fault_pulse_n); endsequence
  sequence trel_s; rel_s ##0 $past(fault_cause) == 2'h2; endsequence
  lock_low_a: assert property (supply_low_lockout |-> ##[1:4] held_s)
    else $error("Fault not low in lockout");
  pulse_min_a: assert property (rel_s |-> lo_q >= PULSE_CYC)
    else $error("Fault pulse too short");
  pulse_len_a: assert property (trel_s |-> lo_q == PULSE_CYC)
    else $error("Timeout pulse length wrong");
  rel_cause_a: assert property (rel_s |-> fault_cause == 2'h0)
    else $error("Cause not cleared at release");
  tout_cnt_a: assert property (timeout_event |->
    hi_q == TIMEOUT_CYC && !fault_pulse_n && fault_cause == 2'h2)
    else $error("Timeout at wrong count");
  no_over_a: assert property (hi_q <= TIMEOUT_CYC)
    else $error("Timer ran past timeout");
  tout_one_a: assert property (timeout_event |=> !timeout_event)
    else $error("Timeout event too long");
  kick_gate_a: assert property (kick_event |-> $past(fault_pulse_n))
    else $error("Kick counted while fault low");
  self_pos_a: assert property ($rose(kick_input_out) |->
    hi_q inside {[SELF:SELF + 2]})
    else $error("Self drive rose at wrong count");
  weak_oe_a: assert property (kick_input_oe)
    else $error("Weak drive not enabled");
endmodule
bind ekw_watchdog ekw_watchdog_monitor #(.TIMEOUT_CYC(TIMEOUT_CYC),
  .PULSE_CYC(PULSE_CYC)) ekw_watchdog_monitor_i (.clk_sys(clk_sys),
  .arst_n(arst_n), .kick_input_out(kick_input_out),
  .kick_input_oe(kick_input_oe), .supply_low_lockout(supply_low_lockout),
  .fault_pulse_n(fault_pulse_n), .fault_cause(fault_cause),
  .timeout_event(timeout_event), .kick_event(kick_event));

// [testbench/test_edge_kicked_watchdog.sv]
// Self-checking bench for the edge kicked watchdog
`timescale 1ns/1ns
module test_edge_kicked_watchdog;
  localparam int unsigned PP = 10;
  logic       clk_sys = 1'b0;
  logic       arst_n  = 1'b0;
  logic       lockout = 1'b0;
  logic       drv_en  = 1'b1;
  logic       drv_lvl = 1'b0;
  logic       pin;
  logic       k_out;
  logic       k_oe;
  logic       fault_n;
  logic [1:0] cause;
  logic       t_ev;
  logic       k_ev;
  logic [3:0] exp_q[$];
  int         bad_count  = 0;
  int         num_checks = 0;
  int         n;
  always #20 clk_sys = ~clk_sys;
  ekw_watchdog #(.TIMEOUT_CYC(64), .PULSE_CYC(PP)) ekw_watchdog_i (
    .clk_sys(clk_sys), .arst_n(arst_n), .kick_input_in(pin),
    .kick_input_out(k_out), .kick_input_oe(k_oe),
    .supply_low_lockout(lockout), .fault_pulse_n(fault_n),
    .fault_cause(cause), .timeout_event(t_ev), .kick_event(k_ev));
  ekw_cpu_model ekw_cpu_model_i (.drive_en(drv_en), .drive_lvl(drv_lvl),
    .kick_input_out(k_out), .kick_input_oe(k_oe), .kick_pin(pin));
  task automatic finish_test();
    if (bad_count == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic check(input logic [3:0] got, input logic [3:0] want);
    num_checks++;
    if (got !== want) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, want);
    end
  endtask
  task automatic step(input int c);
    repeat (c) @(posedge clk_sys);
    #1;
  endtask
  // Bounded wait for a fault level
  task automatic wait_fault(input logic lvl);
    for (n = 0; fault_n !== lvl && n < 400; n++) step(1);
    if (fault_n !== lvl) begin
      check({3'h0, fault_n}, {3'h0, lvl}); // bounded wait
      finish_test();
    end
  endtask
  // A level change while fault is high is one kick note
  task automatic set_pin(input logic lvl);
    if (lvl !== drv_lvl) exp_q.push_back(4'h8);
    drv_lvl = lvl;
  endtask
  // Notes are {kick, timeout, cause}
  // Sampled mid-cycle, away from the edge that launches the events
  always @(negedge clk_sys) begin
    if (k_ev === 1'b1 || t_ev === 1'b1) begin
      if (exp_q.size() == 0) check({k_ev, t_ev, cause}, 4'h0); // spare
      else check({k_ev, t_ev, cause}, exp_q.pop_front()); // event
    end
  end
  initial begin
    void'($urandom(33));
    step(5);
    arst_n = 1'b1;
    wait_fault(1'b1); // power-up pulse
    for (int i = 0; i < 8; i++) begin
      step($urandom_range(40, 5));
      set_pin(~drv_lvl); // toggle
    end
    step(20);
    set_pin(1'b1); // narrow pulse
    #50;
    set_pin(1'b0); // narrow pulse
    // Hold high, then low, past the timeout
    for (int i = 0; i < 2; i++) begin
      step(10);
      set_pin(i == 0);
      exp_q.push_back(4'h6);
      wait_fault(1'b0); // expiry
      wait_fault(1'b1); // release
    end
    step(10);
    lockout = 1'b1;
    step(4);
    check({2'h0, cause}, 4'h1); // lockout cause
    drv_lvl = 1'b1;
    step(20);
    lockout = 1'b0;
    for (n = 0; fault_n !== 1'b1 && n < 100; n++) step(1);
    check({3'h0, n >= PP && n <= PP + 4}, 4'h1); // pulse after
    // Lockout inside a timeout pulse takes over and restarts the pulse
    exp_q.push_back(4'h6);
    wait_fault(1'b0); // expiry
    lockout = 1'b1;
    step(4);
    check({2'h0, cause}, 4'h1); // lockout over timeout
    lockout = 1'b0;
    for (n = 0; fault_n !== 1'b1 && n < 100; n++) step(1);
    check({3'h0, n >= PP && n <= PP + 4}, 4'h1); // full pulse
    // Releasing the pin gives one falling kick, then self service
    step(2);
    repeat (9) exp_q.push_back(4'h8);
    drv_en = 1'b0;
    for (n = 0; exp_q.size() > 0 && n < 600; n++) step(1);
    check({3'h0, exp_q.size() == 0}, 4'h1); // self kicks
    check({3'h0, fault_n}, 4'h1); // no fault
    finish_test();
  end
endmodule
